// ---- hdl/dmr_pkg.sv ----
package dmr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] DMR_IDX_CONFIG    = 8'h55;
  localparam logic [7:0] DMR_IDX_MBIAS_UP  = 8'h58;
  localparam logic [7:0] DMR_IDX_MBIAS_LO  = 8'h59;
  localparam logic [7:0] DMR_IDX_A_PLUS_UP = 8'h62;
  localparam logic [7:0] DMR_IDX_A_PLUS_LO = 8'h63;
  localparam logic [7:0] DMR_IDX_A_MIN_UP  = 8'h64;
  localparam logic [7:0] DMR_IDX_A_MIN_LO  = 8'h65;
  localparam logic [7:0] DMR_IDX_B_PLUS_UP = 8'h66;
  localparam logic [7:0] DMR_IDX_B_PLUS_LO = 8'h67;

  // config field positions
  localparam int DMR_CFG_SAR_FREEZE  = 0;
  localparam int DMR_CFG_TEMP_OVRD   = 1;
  localparam int DMR_CFG_CS_FREEZE   = 2;
  localparam int DMR_CFG_CS_ROUTE    = 3;
  localparam int DMR_CFG_W           = 4;
  localparam logic [3:0] DMR_CFG_RESET = 4'h0;

  // constant channel tags in the lower-nibble registers
  localparam logic [3:0] DMR_TAG_MBIAS  = 4'h1;
  localparam logic [3:0] DMR_TAG_A_PLUS = 4'h6;
  localparam logic [3:0] DMR_TAG_A_MIN  = 4'h7;
  localparam logic [3:0] DMR_TAG_B_PLUS = 4'h8;

  localparam int          DMR_NODES      = 4;
  localparam int          DMR_RES_W      = 12;
  localparam logic [11:0] DMR_DATA_RESET = 12'h000;

  localparam logic [1:0] DMR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DMR_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DMR_NODE_MBIAS  = 2'b00,
    DMR_NODE_A_PLUS = 2'b01,
    DMR_NODE_A_MIN  = 2'b10,
    DMR_NODE_B_PLUS = 2'b11
  } dmr_node_t;

  // one completed conversion, one-cycle valid
  typedef struct packed {
    logic       valid;
    dmr_node_t  node;
    logic [11:0] data;
  } dmr_result_t;

endpackage

// ---- hdl/dmr_diag_monitor_readback.sv ----
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
// Operation
// - SAR freeze set stops SAR updates of monitor data; clear lets them flow while route enable is clear.
// - current-sense freeze set stops current-sense updates; clear lets them flow while route enable is set.
// - route enable set puts current-sense results into the monitor registers.
// - temperature override enable is read/write, resets to zero.
// - config bits 7 to 4 read zero; software writes zero there.
// - upper-byte register shows result bits 11 to 4 in bits 7 to 0.
// - lower-nibble register shows result bits 3 to 0 in bits 7 to 4.
// - mic bias lower register returns tag 0001b in bits 3 to 0.
// - output A plus lower register returns tag 0110b in low nibble.
// - output A minus lower register returns tag 0111b in low nibble.
// - output B plus lower register returns tag 1000b in low nibble.
// - reset clears all monitor data; channel tags remain.
// - monitor registers are read-only; writes leave them unchanged.
module dmr_diag_monitor_readback
  import dmr_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire dmr_result_t       sar_result,
  input  wire dmr_result_t       current_sense_result,
  output logic                   temperature_override_enable,
  output logic                   sar_result_freeze,
  output logic                   current_sense_freeze,
  output logic                   current_sense_route_enable
);

  if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must hold the register map, 9 to 32 bits");
  end

  localparam logic [1:0] ALIGN_ZERO = 2'b00;

  // register storage
  logic [DMR_CFG_W-1:0] cfg;
  logic [DMR_CFG_W-1:0] next_cfg;
  logic [DMR_RES_W-1:0] mon   [DMR_NODES];
  logic [DMR_RES_W-1:0] next_mon [DMR_NODES];

  // bus state
  logic              aw_full;
  logic              next_aw_full;
  logic              w_full;
  logic              next_w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [7:0]        w_byte;
  logic [7:0]        next_w_byte;
  logic              w_lane0;
  logic              next_w_lane0;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_arready;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;

  // word index of an aligned byte address, or all ones when misaligned
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] shifted;
    shifted = a >> 2;
    if (a[1:0] != ALIGN_ZERO || shifted > ADDR_W'(8'hff)) begin
      word_index = 8'hff;
    end else begin
      word_index = shifted[7:0];
    end
  endfunction

  function automatic logic is_mapped(input logic [7:0] idx);
    unique case (idx)
      DMR_IDX_CONFIG,
      DMR_IDX_MBIAS_UP,  DMR_IDX_MBIAS_LO,
      DMR_IDX_A_PLUS_UP, DMR_IDX_A_PLUS_LO,
      DMR_IDX_A_MIN_UP,  DMR_IDX_A_MIN_LO,
      DMR_IDX_B_PLUS_UP, DMR_IDX_B_PLUS_LO: is_mapped = 1'b1;
      default:                              is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] read_value(
    input logic [7:0]           idx,
    input logic [DMR_CFG_W-1:0] c,
    input logic [DMR_RES_W-1:0] m0,
    input logic [DMR_RES_W-1:0] m1,
    input logic [DMR_RES_W-1:0] m2,
    input logic [DMR_RES_W-1:0] m3
  );
    unique case (idx)
      DMR_IDX_CONFIG:    read_value = {4'h0, c};
      DMR_IDX_MBIAS_UP:  read_value = m0[11:4];
      DMR_IDX_MBIAS_LO:  read_value = {m0[3:0], DMR_TAG_MBIAS};
      DMR_IDX_A_PLUS_UP: read_value = m1[11:4];
      DMR_IDX_A_PLUS_LO: read_value = {m1[3:0], DMR_TAG_A_PLUS};
      DMR_IDX_A_MIN_UP:  read_value = m2[11:4];
      DMR_IDX_A_MIN_LO:  read_value = {m2[3:0], DMR_TAG_A_MIN};
      DMR_IDX_B_PLUS_UP: read_value = m3[11:4];
      DMR_IDX_B_PLUS_LO: read_value = {m3[3:0], DMR_TAG_B_PLUS};
      default:           read_value = 8'h00;
    endcase
  endfunction

  // monitor data update
  always_comb begin
    dmr_result_t src;
    logic        frozen;
    src    = sar_result;
    frozen = cfg[DMR_CFG_SAR_FREEZE];
    if (cfg[DMR_CFG_CS_ROUTE]) begin
      src    = current_sense_result;
      frozen = cfg[DMR_CFG_CS_FREEZE];
    end
    for (int n = 0; n < DMR_NODES; n++) begin
      next_mon[n] = mon[n];
      // only a fresh result moves data, so release waits for one
      if (src.valid && !frozen && src.node == dmr_node_t'(n)) begin
        next_mon[n] = src.data;
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int n = 0; n < DMR_NODES; n++) begin
      if (!aresetn) begin
        mon[n] <= DMR_DATA_RESET;
      end else begin
        mon[n] <= next_mon[n];
      end
    end
  end

  // write channel: address and data taken in either order
  always_comb begin
    logic [7:0] widx;
    widx         = word_index(aw_addr);
    next_cfg     = cfg;
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_aw_addr = aw_addr;
    next_w_byte  = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full  = 1'b1;
      next_w_byte  = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_full && w_full && !s_axi_bvalid) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = is_mapped(widx) ? DMR_RESP_OKAY : DMR_RESP_SLVERR;
      // monitor registers ignore writes
      if (widx == DMR_IDX_CONFIG && w_lane0) begin
        next_cfg = w_byte[DMR_CFG_W-1:0];
      end
    end
    next_awready = !next_aw_full;
    next_wready  = !next_w_full;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg           <= DMR_CFG_RESET;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= '0;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= DMR_RESP_OKAY;
    end else begin
      cfg           <= next_cfg;
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      aw_addr       <= next_aw_addr;
      w_byte        <= next_w_byte;
      w_lane0       <= next_w_lane0;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
    end
  end

  // read channel: one outstanding read, data one cycle after address
  always_comb begin
    logic [7:0] ridx;
    ridx         = word_index(s_axi_araddr);
    next_arready = s_axi_arready;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = {24'h000000,
                      read_value(ridx, cfg, mon[0], mon[1], mon[2], mon[3])};
      next_rresp   = is_mapped(ridx) ? DMR_RESP_OKAY : DMR_RESP_SLVERR;
    end
    if (!s_axi_rvalid && !s_axi_arready) begin
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= DMR_RESP_OKAY;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // control bits registered from next_cfg, so they track the config flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temperature_override_enable <= 1'b0;
      sar_result_freeze           <= 1'b0;
      current_sense_freeze        <= 1'b0;
      current_sense_route_enable  <= 1'b0;
    end else begin
      temperature_override_enable <= next_cfg[DMR_CFG_TEMP_OVRD];
      sar_result_freeze           <= next_cfg[DMR_CFG_SAR_FREEZE];
      current_sense_freeze        <= next_cfg[DMR_CFG_CS_FREEZE];
      current_sense_route_enable  <= next_cfg[DMR_CFG_CS_ROUTE];
    end
  end

endmodule

// ---- verification/dmr_diag_monitor_readback_sva.sv ----
`timescale 1ns/10ps
module dmr_chk
  import dmr_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              temperature_override_enable,
  input wire logic              sar_result_freeze,
  input wire logic              current_sense_freeze,
  input wire logic              current_sense_route_enable
);
  logic [ADDR_W-1:0] rd_a;
  logic [ADDR_W-1:0] next_rd_a;
  logic [3:0]        ctrl;
  logic              ok;
  assign ctrl = {current_sense_route_enable, current_sense_freeze,
                 temperature_override_enable, sar_result_freeze};
  assign ok = s_axi_rvalid && s_axi_rresp == DMR_RESP_OKAY;
  // address of the read in flight, to know what rdata should hold
  always_comb
    next_rd_a = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_a;
  always_ff @(posedge aclk) rd_a <= next_rd_a;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_hi_zero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("rdata high bits set");
  property p_cfg;
    ok && rd_a == ADDR_W'({DMR_IDX_CONFIG, 2'b00})
      |-> s_axi_rdata[7:0] == {4'h0, ctrl};
  endproperty
  a_cfg: assert property (p_cfg) else $error("config read mismatch");
  property p_tag_mb;
    ok && rd_a == ADDR_W'({DMR_IDX_MBIAS_LO, 2'b00})
      |-> s_axi_rdata[3:0] == DMR_TAG_MBIAS;
  endproperty
  a_tag_mb: assert property (p_tag_mb) else $error("mic bias tag wrong");
  property p_tag_bp;
    ok && rd_a == ADDR_W'({DMR_IDX_B_PLUS_LO, 2'b00})
      |-> s_axi_rdata[3:0] == DMR_TAG_B_PLUS;
  endproperty
  a_tag_bp: assert property (p_tag_bp) else $error("out b plus tag wrong");
  property p_ctrl;
    $changed(ctrl) |-> $rose(s_axi_bvalid);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("controls moved without write");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_err;
    s_axi_rvalid && s_axi_rresp == DMR_RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error read not zero");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
endmodule
bind dmr_diag_monitor_readback dmr_chk #(.ADDR_W(ADDR_W)) dmr_chk_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .temperature_override_enable, .sar_result_freeze,
  .current_sense_freeze, .current_sense_route_enable);

// ---- verification/tb.sv ----
`timescale 1ns/10ps
module tb
  import dmr_pkg::*;
();
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        temperature_override_enable, sar_result_freeze;
  logic        current_sense_freeze, current_sense_route_enable;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, cfg;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  dmr_result_t sar_result, current_sense_result;
  logic [11:0] mem [4];
  logic [33:0] expq [$];
  int          n_errors, compares, seed;
  localparam logic [7:0] up_i [4] = '{DMR_IDX_MBIAS_UP, DMR_IDX_A_PLUS_UP,
                                      DMR_IDX_A_MIN_UP, DMR_IDX_B_PLUS_UP};
  localparam logic [3:0] tags [4] = '{DMR_TAG_MBIAS, DMR_TAG_A_PLUS,
                                      DMR_TAG_A_MIN, DMR_TAG_B_PLUS};
  localparam logic [3:0] vals [5] = '{4'h1, 4'h0, 4'h8, 4'hc, 4'h2};
  dmr_diag_monitor_readback #(.ADDR_W(10)) dmr_diag_monitor_readback_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sar_result, .current_sense_result,
    .temperature_override_enable, .sar_result_freeze,
    .current_sense_freeze, .current_sense_route_enable);
  function automatic logic [9:0] ad(input logic [7:0] i);
    return {i, 2'b00};
  endfunction
  task chk(input string nm, input logic [33:0] ex, input logic [33:0] got);
    compares++;
    if (got !== ex) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task tally_and_finish();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ready is looked at on the falling edge, where it is settled
  task wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    logic pa, pw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      @(posedge aclk);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {32'h0, er}, {32'h0, s_axi_bresp});
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    logic p;
    expq.push_back({er, 24'h0, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    p = 1'b1;
    while (p) begin
      @(negedge aclk);
      p = !s_axi_arready;
      @(posedge aclk);
      s_axi_arvalid <= p;
    end
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  always @(negedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk("rdata", expq.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  // model keeps a result only if its source is routed in and not frozen
  task res(input logic c, input logic [1:0] n);
    logic [11:0] d;
    d = 12'($random(seed));
    @(posedge aclk);
    if (c) current_sense_result <= {1'b1, n, d};
    else sar_result <= {1'b1, n, d};
    @(posedge aclk);
    current_sense_result.valid <= 1'b0;
    sar_result.valid <= 1'b0;
    if (c == cfg[3] && !(c ? cfg[2] : cfg[0])) mem[n] = d;
  endtask
  task chk_all();
    for (int i = 0; i < DMR_NODES; i++) begin
      rd(ad(up_i[i]), mem[i][11:4], DMR_RESP_OKAY);
      rd(ad(up_i[i] + 8'h1), {mem[i][3:0], tags[i]}, DMR_RESP_OKAY);
    end
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    #(50 * 6000);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 22'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    sar_result = '0;
    current_sense_result = '0;
    mem = '{default: 12'h000};
    cfg = 4'h0;
    seed = 70976;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ad(DMR_IDX_CONFIG), 8'h00, DMR_RESP_OKAY);
    chk_all();
    for (int k = 0; k < 5; k++) begin
      wr(ad(DMR_IDX_CONFIG), {4'h0, vals[k]}, DMR_RESP_OKAY);
      cfg = vals[k];
      chk("controls", {30'h0, cfg}, {30'h0, current_sense_route_enable,
          current_sense_freeze, temperature_override_enable,
          sar_result_freeze});
      rd(ad(DMR_IDX_CONFIG), {4'h0, cfg}, DMR_RESP_OKAY);
      for (int i = 0; i < DMR_NODES; i++) begin
        res(1'b0, 2'(i));
        res(1'b1, 2'(i));
      end
      chk_all();
    end
    wr(ad(DMR_IDX_MBIAS_UP), 8'hff, DMR_RESP_OKAY);
    wr(ad(DMR_IDX_B_PLUS_LO), 8'hff, DMR_RESP_OKAY);
    chk_all();
    // lane 0 strobe low: config must not move
    s_axi_wstrb <= 4'he;
    wr(ad(DMR_IDX_CONFIG), 8'h0f, DMR_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(ad(DMR_IDX_CONFIG), {4'h0, cfg}, DMR_RESP_OKAY);
    rd(ad(DMR_IDX_CONFIG) + 10'h1, 8'h00, DMR_RESP_SLVERR);
    rd(10'h000, 8'h00, DMR_RESP_SLVERR);
    wr(10'h000, 8'h5a, DMR_RESP_SLVERR);
    repeat (4) @(posedge aclk);
    tally_and_finish();
  end
endmodule
